// *** verilog/itoc_map.svh ***
`ifndef ITOC_MAP_SVH
`define ITOC_MAP_SVH
// =====================================================
// Register byte addresses (index times four)
`define ITOC_IDX_INTCTL 8'h0b
`define ITOC_IDX_INTCTL_MIR 8'h8b
`define ITOC_IDX_OPTIONS 8'h81
`define ITOC_IDX_PINCTL 8'h90
`define ITOC_ADDR_INTCTL 12'h02c
`define ITOC_ADDR_INTCTL_MIR 12'h22c
`define ITOC_ADDR_OPTIONS 12'h204
`define ITOC_ADDR_PINCTL 12'h240
// =====================================================
// Options field positions
`define ITOC_OPT_PULLUP_DIS 7
`define ITOC_OPT_EDGE_SEL 6
`define ITOC_OPT_CLK_SRC 5
`define ITOC_OPT_SRC_EDGE 4
`define ITOC_OPT_PSA 3
// =====================================================
// Interrupt control field positions
`define ITOC_IC_GIE 7
`define ITOC_IC_PERIPHERAL_IRQ_ENABLE 6
`define ITOC_IC_TIMER_OVERFLOW_IRQ_ENABLE 5
`define ITOC_IC_EXTIE 4
`define ITOC_IC_PCIE 3
`define ITOC_IC_T0F 2
`define ITOC_IC_EXTF 1
`define ITOC_IC_PCF 0
// =====================================================
// Reset values
`define ITOC_OPT_RESET 8'hff
`define ITOC_IC_RESET 8'h00
// =====================================================
// Timing: instruction cycle is four core clocks
`define ITOC_ICYC_DIV 2'd3
`define ITOC_ISR_VECTOR 13'h0004
`endif

// *** verilog/itoc_pkg.sv ***
package itoc_pkg;
   typedef struct packed {
      logic pullup_dis;
      logic edge_sel;
      logic clk_src;
      logic src_edge;
      logic prescaler_assign;
      logic [2:0] rate;
   } itoc_opt_s;
   typedef struct packed {
      logic global_irq_enable;
      logic peripheral_irq_enable;
      logic timer_overflow_irq_enable;
      logic extie;
      logic pcie;
      logic t0f;
      logic extf;
      logic pcf;
   } itoc_ic_s;
endpackage

// *** verilog/itoc_prescaler.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "itoc_map.svh"
// =====================================================
// Shared prescaler: 8-bit ripple count, tap by rate
module itoc_prescaler (
   input wire logic pclk, // Core clock
   input wire logic presetn, // Async reset, active low
   input wire logic tick, // Source tick to divide
   input wire logic to_wdt, // Assigned to watchdog
   input wire logic [2:0] rate, // Division code
   input wire logic clear, // Restart count
   output logic out_tick // Divided tick
);
   logic [7:0] cnt_ff;
   logic [7:0] nxt_cnt;
   logic [8:0] carry;
   // Carry chain; bit k toggling from 1 to 0 marks 2^(k+1)
   genvar gi;
   assign carry[0] = tick;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_bit
         assign nxt_cnt[gi] = cnt_ff[gi] ^ carry[gi];
         assign carry[gi+1] = carry[gi] & cnt_ff[gi];
      end
   endgenerate
   // Count the ticks
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff <= 8'h00;
      end else if (clear) begin
         cnt_ff <= 8'h00;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end
   // Timer taps 1:2^(n+1), watchdog 1:2^n with 000 bypass
   always_comb begin
      if (to_wdt) begin
         out_tick = (rate == 3'h0) ? tick : carry[rate];
      end else begin
         out_tick = carry[{1'b0, rate} + 4'h1];
      end
   end
endmodule
`default_nettype wire

// *** verilog/itoc_top.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "itoc_map.svh"
module itoc_top
   import itoc_pkg::*;
(
   input wire logic pclk, // Core clock, 20 MHz
   input wire logic presetn, // Async reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic pwrite, // APB direction
   input wire logic [11:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error, unmapped
   input wire logic ext_irq_pin, // External interrupt pin
   input wire logic timer_ext_clock_pin, // Timer external clock
   input wire logic [3:0] upper_port_pins, // Upper port inputs
   input wire logic [7:0] port_latch, // Upper port output latches
   input wire logic periph_irq, // Comparator request, pre-masked
   input wire logic irq_ack, // Core accepts interrupt
   output logic irq_req, // Interrupt request to core
   output logic [12:0] irq_vector, // Vector loaded on accept
   output logic [7:0] pullup_en, // Weak pull-up enables
   output logic [7:0] timer_zero, // Timer counter value
   output logic wdt_tick // Watchdog time-base tick
);

   // Software-visible registers
   itoc_opt_s opt_ff;
   itoc_ic_s ic_ff;

   // Timer, divider and pin history
   logic [7:0] tmr_ff;
   logic [1:0] icyc_ff;
   logic ext_d_ff;
   logic tck_d_ff;
   logic [3:0] port_d_ff;
   logic pins_valid_ff;

   // Bus decode and read path
   logic [31:0] nxt_rdata;
   logic wr_en;
   logic rd_en;
   logic hit_ic;
   logic hit_opt;
   logic hit_pin;
   logic tmr_wr;

   // Event strobes and request terms
   logic icyc_tick;
   logic ext_edge;
   logic tck_edge;
   logic tmr_src;
   logic tmr_inc;
   logic tmr_wrap;
   logic [3:0] pin_chg;
   logic port_chg;
   logic ps_tick;
   logic ps_clear;
   logic t0_req;
   logic ext_req;
   logic pc_req;
   logic per_req;
   logic nxt_irq;

   // =====================================================
   // APB decode; zero wait states, access phase always ready
   assign hit_opt = (paddr == `ITOC_ADDR_OPTIONS);
   assign hit_ic = (paddr == `ITOC_ADDR_INTCTL) || (paddr == `ITOC_ADDR_INTCTL_MIR);
   assign hit_pin = (paddr == `ITOC_ADDR_PINCTL);

   // Strobes; writes land at the access edge only
   assign wr_en = psel && penable && pwrite && (hit_opt || hit_ic || hit_pin);
   assign rd_en = psel && !penable && !pwrite;
   assign tmr_wr = wr_en && hit_pin;

   // Read mux; timer value readable for polling
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      if (hit_opt) begin
         nxt_rdata[7:0] = opt_ff;
      end else if (hit_ic) begin
         nxt_rdata[7:0] = ic_ff;
      end else if (hit_pin) begin
         nxt_rdata[7:0] = tmr_ff;
      end
   end

   // Read data registered in setup, so outputs stay flopped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_en) begin
         prdata <= nxt_rdata;
      end
   end

   // Ready and error flopped from the setup phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !(hit_opt || hit_ic || hit_pin);
      end
   end

   // =====================================================
   // Options register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         opt_ff <= `ITOC_OPT_RESET;
      end else if (wr_en && hit_opt) begin
         opt_ff <= pwdata[7:0];
      end
   end

   // Pull-ups off when disabled, else follow latches
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pullup_en <= 8'h00;
      end else begin
         pullup_en <= opt_ff.pullup_dis ? 8'h00 : port_latch;
      end
   end

   // =====================================================
   // Instruction-cycle enable, one pulse per four clocks
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         icyc_ff <= 2'd0;
      end else begin
         icyc_ff <= (icyc_ff == `ITOC_ICYC_DIV) ? 2'd0 : icyc_ff + 2'd1;
      end
   end

   // Tick on the last phase of the count
   assign icyc_tick = (icyc_ff == `ITOC_ICYC_DIV);

   // Previous pin samples for edge detection; pins are synchronous
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_d_ff <= 1'b0;
         tck_d_ff <= 1'b0;
         port_d_ff <= 4'h0;
      end else begin
         ext_d_ff <= ext_irq_pin;
         tck_d_ff <= timer_ext_clock_pin;
         port_d_ff <= upper_port_pins;
      end
   end

   // Edges held off until the first pin sample is taken, so a pin
   // already high at reset release gives no false edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pins_valid_ff <= 1'b0;
      end else begin
         pins_valid_ff <= 1'b1;
      end
   end

   // Edge selection on external pin
   assign ext_edge = pins_valid_ff &&
                     (opt_ff.edge_sel ? (ext_irq_pin && !ext_d_ff) : (!ext_irq_pin && ext_d_ff));

   // Timer clock pin edge: 1 falling, 0 rising
   assign tck_edge = pins_valid_ff &&
                     (opt_ff.src_edge ? (!timer_ext_clock_pin && tck_d_ff) :
                      (timer_ext_clock_pin && !tck_d_ff));

   // Source pick; external edges count once per selected pin edge
   assign tmr_src = opt_ff.clk_src ? tck_edge : icyc_tick;

   // Per-pin change; any one pin sets the flag
   genvar pi;
   generate
      for (pi = 0; pi < 4; pi = pi + 1) begin : g_pin
         assign pin_chg[pi] = pins_valid_ff && (upper_port_pins[pi] != port_d_ff[pi]);
      end
   endgenerate
   assign port_chg = |pin_chg;

   // =====================================================
   // Shared prescaler; source is timer or watchdog clock
   assign ps_clear = tmr_wr || (wr_en && hit_opt);

   // One divider, steered by the assign bit
   itoc_prescaler u_ps (
      .pclk(pclk),
      .presetn(presetn),
      .tick(opt_ff.prescaler_assign ? icyc_tick : tmr_src),
      .to_wdt(opt_ff.prescaler_assign),
      .rate(opt_ff.rate),
      .clear(ps_clear),
      .out_tick(ps_tick)
   );

   // Watchdog gets prescaled tick or raw cycle tick
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wdt_tick <= 1'b0;
      end else begin
         wdt_tick <= opt_ff.prescaler_assign ? ps_tick : icyc_tick;
      end
   end

   // Timer bypasses prescaler when it is with the watchdog
   assign tmr_inc = opt_ff.prescaler_assign ? tmr_src : ps_tick;
   // Overflow on any increment strobe at 0xff, even when a same-cycle load wins
   assign tmr_wrap = tmr_inc && (tmr_ff == 8'hff);

   // Counter; a software load wins over a same-cycle count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tmr_ff <= 8'h00;
      end else if (tmr_wr) begin
         tmr_ff <= pwdata[7:0];
      end else if (tmr_inc) begin
         tmr_ff <= tmr_ff + 8'h01;
      end
   end

   // Count copy to the port, flopped like every output
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_zero <= 8'h00;
      end else begin
         timer_zero <= tmr_ff;
      end
   end

   // =====================================================
   // Interrupt control: enables by software; flags set win over clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ic_ff <= `ITOC_IC_RESET;
      end else begin
         if (wr_en && hit_ic) begin
            ic_ff <= pwdata[7:0];
         end
         if (irq_ack) begin
            ic_ff.global_irq_enable <= 1'b0;
         end

         // Hardware sets regardless of enables
         if (tmr_wrap) begin
            ic_ff.t0f <= 1'b1;
         end
         if (ext_edge) begin
            ic_ff.extf <= 1'b1;
         end
         if (port_chg) begin
            ic_ff.pcf <= 1'b1;
         end
      end
   end

   // Per-source terms; peripheral also needs its own group enable
   assign t0_req = ic_ff.timer_overflow_irq_enable && ic_ff.t0f;
   assign ext_req = ic_ff.extie && ic_ff.extf;
   assign pc_req = ic_ff.pcie && ic_ff.pcf;
   assign per_req = ic_ff.peripheral_irq_enable && periph_irq;

   // Global enable gates all; accept drops the flopped request one clock later
   assign nxt_irq = ic_ff.global_irq_enable && !irq_ack && (t0_req || ext_req || pc_req || per_req);

   // Request and vector flopped for the core
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_req <= 1'b0;
         irq_vector <= 13'h0000;
      end else begin
         irq_req <= nxt_irq;
         irq_vector <= `ITOC_ISR_VECTOR;
      end
   end

endmodule
`default_nettype wire

// *** testbench/itoc_top_props.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "itoc_map.svh"
// ========
// Port checks: APB answer, decode, pull-ups, vector
module itoc_top_props (
   input wire logic pclk, // Core clock
   input wire logic presetn, // Reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB access
   input wire logic pwrite, // APB direction
   input wire logic [11:0] paddr, // APB address
   input wire logic [31:0] prdata, // APB read data
   input wire logic pready, // APB ready
   input wire logic pslverr, // APB error
   input wire logic irq_ack, // Core accept
   input wire logic irq_req, // Request to core
   input wire logic [12:0] irq_vector, // Service vector
   input wire logic [7:0] port_latch, // Port latches
   input wire logic [7:0] pullup_en // Pull-up enables
);
   logic mapped;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Own decode, so a wrong map shows as a bad error flag
   assign mapped = paddr == `ITOC_ADDR_INTCTL || paddr == `ITOC_ADDR_INTCTL_MIR ||
      paddr == `ITOC_ADDR_OPTIONS || paddr == `ITOC_ADDR_PINCTL;
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_done;
      psel && penable && pready;
   endsequence
   a_ready_after_setup: assert property (s_setup |=> pready)
      else $error("no ready after setup");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_err_decode: assert property (s_done |-> pslverr == !mapped)
      else $error("error flag wrong");
   a_rdata_width: assert property (s_done ##0 !pwrite |-> prdata[31:8] == 24'h0)
      else $error("upper read bits set");
   a_unmapped_zero: assert property (s_done ##0 (!pwrite && !mapped) |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   a_pullup_follow: assert property (pullup_en != 8'h00 |-> pullup_en == $past(port_latch))
      else $error("pull-ups not latch");
   a_ack_drops_req: assert property (irq_ack |=> !irq_req)
      else $error("request after accept");
   a_vector_fixed: assert property ($past(presetn) |-> irq_vector == `ITOC_ISR_VECTOR)
      else $error("vector wrong");
endmodule
`default_nettype wire

// *** testbench/itoc_core_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ========
// Core side: accepts a request after a chosen delay
module itoc_core_model (
   input wire logic pclk, // Core clock
   input wire logic presetn, // Reset, active low
   input wire logic irq_req, // Request from block
   input wire logic ack_en, // Core may accept
   input wire logic [3:0] ack_delay, // Cycles before accept
   output logic irq_ack // Accept pulse
);
   logic [3:0] wait_ff;
   // One pulse per request; the count restarts so no double accept
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_ff <= 4'h0;
         irq_ack <= 1'b0;
      end else begin
         irq_ack <= 1'b0;
         if (!irq_req || irq_ack) wait_ff <= 4'h0;
         else if (ack_en && wait_ff == ack_delay) irq_ack <= 1'b1;
         else wait_ff <= wait_ff + 4'h1;
      end
   end
endmodule
`default_nettype wire

// *** testbench/itoc_top_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "itoc_map.svh"
// ========
// Bench: APB master, pins, core model
module itoc_top_tb;
   localparam logic [11:0] ad_ic = `ITOC_ADDR_INTCTL;
   localparam logic [11:0] ad_mir = `ITOC_ADDR_INTCTL_MIR;
   localparam logic [11:0] ad_opt = `ITOC_ADDR_OPTIONS;
   localparam logic [11:0] ad_tmr = `ITOC_ADDR_PINCTL;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ext_irq_pin, timer_ext_clock_pin;
   logic periph_irq, irq_ack, irq_req, wdt_tick, ack_en, last_err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic [3:0] upper_port_pins;
   logic [7:0] port_latch, pullup_en, timer_zero;
   logic [12:0] irq_vector;
   int failures, checks_done, g;
   itoc_top u_itoc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ext_irq_pin(ext_irq_pin), .timer_ext_clock_pin(timer_ext_clock_pin),
      .upper_port_pins(upper_port_pins), .port_latch(port_latch), .periph_irq(periph_irq),
      .irq_ack(irq_ack), .irq_req(irq_req), .irq_vector(irq_vector), .pullup_en(pullup_en),
      .timer_zero(timer_zero), .wdt_tick(wdt_tick));
   itoc_core_model u_itoc_core_model (.pclk(pclk), .presetn(presetn), .irq_req(irq_req),
      .ack_en(ack_en), .ack_delay(4'h2), .irq_ack(irq_ack));
   // ========
   // Clock, 50 ns period
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      if (failures == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // One APB transfer; an idle edge after it avoids double drives
   task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         check(32'h0, 32'h1);
         stop_test();
      end
      rdata = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      check(rdata, {24'h0, e});
   endtask
   task automatic ext_set(input logic v);
      ext_irq_pin <= v;
      repeat (4) @(posedge pclk);
   endtask
   task automatic pulses(input int n);
      repeat (n) begin
         timer_ext_clock_pin <= 1'b0;
         repeat (4) @(posedge pclk);
         timer_ext_clock_pin <= 1'b1;
         repeat (4) @(posedge pclk);
      end
      repeat (6) @(posedge pclk);
   endtask
   task automatic gap(output int c);
      c = 0;
      do begin
         @(posedge pclk);
         c++;
      end while (wdt_tick !== 1'b1 && c < 1200);
      if (wdt_tick !== 1'b1) begin
         check(32'h0, 32'h1);
         stop_test();
      end
   endtask
   // Hang guard
   initial begin
      repeat (30000) @(posedge pclk);
      check(32'h0, 32'h1);
      stop_test();
   end
   // ========
   // Main sequence
   initial begin
      {presetn, psel, penable, pwrite, ext_irq_pin, timer_ext_clock_pin, periph_irq, ack_en} = 8'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      upper_port_pins = 4'h0;
      port_latch = 8'ha5;
      failures = 0;
      checks_done = 0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd_chk(ad_opt, 8'hff);
      rd_chk(ad_mir, 8'h00);
      rd_chk(12'h100, 8'h00);
      check(last_err, 1'b1);
      apb(1'b1, ad_opt, 8'h3c);
      rd_chk(ad_opt, 8'h3c);
      check(pullup_en, 8'ha5);
      apb(1'b1, ad_opt, 8'hf8);
      repeat (2) @(posedge pclk);
      check(pullup_en, 8'h00);
      // Pin interrupt, accept by core
      apb(1'b1, ad_ic, 8'h10);
      ext_set(1'b1);
      rd_chk(ad_ic, 8'h12);
      check(irq_req, 1'b0);
      apb(1'b1, ad_ic, 8'h92);
      repeat (2) @(posedge pclk);
      check(irq_req, 1'b1);
      ack_en <= 1'b1;
      repeat (8) @(posedge pclk);
      check(irq_req, 1'b0);
      check(irq_vector, 13'h0004);
      rd_chk(ad_ic, 8'h12);
      ack_en <= 1'b0;
      apb(1'b1, ad_ic, 8'h10);
      ext_set(1'b0);
      rd_chk(ad_ic, 8'h10);
      apb(1'b1, ad_opt, 8'hb8);
      ext_set(1'b1);
      rd_chk(ad_ic, 8'h10);
      ext_set(1'b0);
      rd_chk(ad_ic, 8'h12);
      // Port change and peripheral gating
      apb(1'b1, ad_ic, 8'h08);
      upper_port_pins <= 4'h8;
      repeat (4) @(posedge pclk);
      rd_chk(ad_mir, 8'h09);
      apb(1'b1, ad_mir, 8'h89);
      repeat (2) @(posedge pclk);
      check(irq_req, 1'b1);
      apb(1'b1, ad_mir, 8'h88);
      repeat (2) @(posedge pclk);
      check(irq_req, 1'b0);
      periph_irq <= 1'b1;
      apb(1'b1, ad_ic, 8'h80);
      repeat (2) @(posedge pclk);
      check(irq_req, 1'b0);
      apb(1'b1, ad_ic, 8'hc0);
      repeat (2) @(posedge pclk);
      check(irq_req, 1'b1);
      periph_irq <= 1'b0;
      // Timer from external pin: falling 1:1, then rising 1:2
      apb(1'b1, ad_opt, 8'h38);
      apb(1'b1, ad_tmr, 8'h00);
      pulses(3);
      rd_chk(ad_tmr, 8'h02);
      apb(1'b1, ad_opt, 8'h20);
      apb(1'b1, ad_tmr, 8'h00);
      pulses(4);
      rd_chk(ad_tmr, 8'h02);
      check(timer_zero, 8'h02);
      // Internal clock, prescaler 1:4 on timer: one count per 16 clocks
      apb(1'b1, ad_opt, 8'h01);
      apb(1'b1, ad_tmr, 8'h00);
      repeat (160) @(posedge pclk);
      rd_chk(ad_tmr, 8'h0a);
      // Internal clock overflow sets flag with enables off
      apb(1'b1, ad_opt, 8'h08);
      apb(1'b1, ad_tmr, 8'hf0);
      apb(1'b1, ad_ic, 8'h00);
      rd_chk(ad_ic, 8'h00);
      repeat (80) @(posedge pclk);
      rd_chk(ad_ic, 8'h04);
      apb(1'b1, ad_ic, 8'ha4);
      repeat (2) @(posedge pclk);
      check(irq_req, 1'b1);
      // Watchdog tick spacing for every rate code
      for (int r = 0; r < 8; r++) begin
         apb(1'b1, ad_opt, 8'h08 | 8'(r));
         gap(g);
         gap(g);
         gap(g);
         check(g, 4 << r);
      end
      stop_test();
   end
endmodule
bind itoc_top itoc_top_props u_itoc_top_props (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .irq_ack(irq_ack), .irq_req(irq_req), .irq_vector(irq_vector),
   .port_latch(port_latch), .pullup_en(pullup_en));
`default_nettype wire
